// file: inc/ssf_defs.svh
// offsets, field positions, reset values and codes for the special-function block
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH
`define SSF_WORD_ONE_ADDR   16'h0282
`define SSF_WORD_TWO_ADDR   16'h0284
`define SSF_WORD_ONE_RESET  16'h0000
`define SSF_WORD_TWO_RESET  16'h0000
`define SSF_W1_INHIBIT_BIT  11
`define SSF_W1_PHASE_BIT    12
`define SSF_W1_ENCOUT_BIT   13
`define SSF_W1_KEEP_MASK    16'hf800
`define SSF_W2_RAMP_BIT     0
`define SSF_W2_UVAUTO_BIT   2
`define SSF_W2_TEMPHIDE_BIT 7
`define SSF_SPDLIM_ALWAYS   8'h10
`define SSF_TQ_POS_CODE     8'h48
`define SSF_TQ_NEG_CODE     8'h49
`define SSF_SYNC_STAGES     3
`endif

// file: inc/ssf_pkg.sv
// shared types of the special-function block
package ssf_pkg;
  // pins sampled through the synchroniser, in bit order
  typedef struct packed {
    logic speed_limit_input;
    logic speed_select1;
    logic speed_select0;
    logic torque_source_sel1;
    logic torque_source_sel0;
    logic negative_torque_input;
    logic positive_torque_input;
    logic forward_limit_input;
    logic reverse_limit_input;
  } ssf_pins_type;

  // parameter access from the communication link
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ssf_param_req_type;

  // raw detector events from the drive
  typedef struct packed {
    logic phase_loss;
    logic enc_out_err;
    logic undervoltage;
    logic uv_clear;
    logic overtemp;
  } ssf_detect_type;
endpackage

// file: core/ssf_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module ssf_pin_sync
  import ssf_pkg::*;
#(
  parameter int WIDTH = 9
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } ssf_sync_state_type;

  ssf_sync_state_type st_q;
  ssf_sync_state_type st_d;

  // stage one feeds only stage two; the agreement check looks at two and three
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.level[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;
endmodule

// file: core/ssf_core.sv
// special-function configuration words and the drive logic they steer
// Overview of operation
// - inhibit bit clear: position pulses pass whatever the travel limits show
// - inhibit set in pulse-position mode: reverse limit blocks reverse pulses, forward limit blocks forward
// - inhibit set in pulse-position mode and both limits active: pulses blocked in both directions
// - word one bit 12 low enables phase-loss alarm, high suppresses it
// - word one bit 13 low enables encoder-output alarm, high suppresses it
// - word two bit 0 selects speed-limit ramp using speed selects and ramp params
// - torque source follows the two source selects, torque inputs gate and sign it
// - both or neither torque input gives zero, positive passes, negative inverts
// - speed-limit mode 0x10 keeps the speed limit on without the input
// - word two bit 2 low latches undervoltage until cleared, high clears itself
// - word two bit 7 low shows over-temperature warning, high hides it
`timescale 1ns/1ns
`include "ssf_defs.svh"
module ssf_core
  import ssf_pkg::*;
#(
  parameter int CMD_W  = 16,
  parameter int TIME_W = 16
)(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  // parameter access from the link
  input  wire ssf_param_req_type        param_req,
  output logic      [15:0]              param_rdata,
  // digital input pins
  input  wire ssf_pins_type             pins,
  // pulse-position commands
  input  wire logic                     pulse_position_mode,
  input  wire logic                     pulse_fwd_in,
  input  wire logic                     pulse_rev_in,
  output logic                          pulse_fwd_out,
  output logic                          pulse_rev_out,
  // detectors and alarms
  input  wire ssf_detect_type           detect,
  output logic                          phase_loss_alarm,
  output logic                          encoder_output_error_alarm,
  output logic                          undervoltage_fault,
  output logic                          motor_overtemp_warning,
  // torque path
  input  wire logic signed [CMD_W-1:0]  torque_cmd_in,
  output logic             [1:0]        torque_source_sel,
  output logic signed      [CMD_W-1:0]  torque_out,
  // speed limit path
  input  wire logic        [7:0]        speed_limit_mode_param,
  input  wire logic        [TIME_W-1:0] accel_time_param,
  input  wire logic        [TIME_W-1:0] decel_time_param,
  input  wire logic        [TIME_W-1:0] scurve_time_param,
  output logic                          speed_limit_active,
  output logic             [1:0]        speed_limit_sel,
  output logic             [TIME_W-1:0] accel_time,
  output logic             [TIME_W-1:0] decel_time,
  output logic             [TIME_W-1:0] scurve_time
);
  localparam logic signed [CMD_W-1:0] CMD_MAX = {1'b0, {(CMD_W-1){1'b1}}};
  localparam logic signed [CMD_W-1:0] CMD_MIN = {1'b1, {(CMD_W-1){1'b0}}};

  typedef struct packed {
    logic [15:0]              word_one;
    logic [15:0]              special_function_word_two;
    logic [15:0]              rdata;
    logic                     fwd;
    logic                     rev;
    logic                     phase;
    logic                     encout;
    logic                     uv;
    logic                     temp;
    logic [1:0]               tsel;
    logic signed [CMD_W-1:0]  torque;
    logic                     spdlim;
    logic [1:0]               spdsel;
    logic [TIME_W-1:0]        acc;
    logic [TIME_W-1:0]        dec;
    logic [TIME_W-1:0]        scv;
  } ssf_state_type;

  ssf_state_type st_q;
  ssf_state_type st_d;
  ssf_pins_type  pin_lvl;

  // pins come from outside the clock domain
  ssf_pin_sync #(
    .WIDTH     ($bits(ssf_pins_type))
  ) u_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .pin_in    (pins),
    .level_out (pin_lvl)
  );

  // negation saturates so the most negative command cannot wrap to itself
  function automatic logic signed [CMD_W-1:0] neg_sat(input logic signed [CMD_W-1:0] v);
    neg_sat = (v == CMD_MIN) ? CMD_MAX : -v;
  endfunction

  logic inhibit;
  logic uv_auto;
  assign inhibit = st_q.word_one[`SSF_W1_INHIBIT_BIT];
  assign uv_auto = st_q.special_function_word_two[`SSF_W2_UVAUTO_BIT];

  always_comb
  begin
    st_d = st_q;
    // parameter writes; word one keeps only bits 11 to 15 of the write, word two is stored as written
    if (param_req.wr_en && param_req.addr == `SSF_WORD_ONE_ADDR)
    begin
      st_d.word_one = param_req.wdata & `SSF_W1_KEEP_MASK;
    end
    if (param_req.wr_en && param_req.addr == `SSF_WORD_TWO_ADDR)
    begin
      st_d.special_function_word_two = param_req.wdata;
    end
    // registered read, unmapped offsets read zero
    if (param_req.rd_en)
    begin
      unique case (param_req.addr)
        `SSF_WORD_ONE_ADDR: st_d.rdata = st_q.word_one;
        `SSF_WORD_TWO_ADDR: st_d.rdata = st_q.special_function_word_two;
        default:            st_d.rdata = 16'h0000;
      endcase
    end
    // travel-limit pulse gating applies only in pulse-position mode
    st_d.fwd = pulse_fwd_in;
    st_d.rev = pulse_rev_in;
    if (inhibit && pulse_position_mode)
    begin
      st_d.fwd = pulse_fwd_in && !pin_lvl.forward_limit_input;
      st_d.rev = pulse_rev_in && !pin_lvl.reverse_limit_input;
    end
    // alarm detection enables
    st_d.phase  = detect.phase_loss && !st_q.word_one[`SSF_W1_PHASE_BIT];
    st_d.encout = detect.enc_out_err && !st_q.word_one[`SSF_W1_ENCOUT_BIT];
    // undervoltage: a new detection wins over any clear in the same cycle
    if (detect.undervoltage)
    begin
      st_d.uv = 1'b1;
    end
    else if (uv_auto || detect.uv_clear)
    begin
      st_d.uv = 1'b0;
    end
    st_d.temp = detect.overtemp && !st_q.special_function_word_two[`SSF_W2_TEMPHIDE_BIT];
    // torque source and sign
    st_d.tsel = {pin_lvl.torque_source_sel1, pin_lvl.torque_source_sel0};
    unique case ({pin_lvl.positive_torque_input, pin_lvl.negative_torque_input})
      2'b10:   st_d.torque = torque_cmd_in;
      2'b01:   st_d.torque = neg_sat(torque_cmd_in);
      default: st_d.torque = '0;
    endcase
    // speed limit enable and ramp selection
    st_d.spdlim = (speed_limit_mode_param == `SSF_SPDLIM_ALWAYS)
                  || pin_lvl.speed_limit_input;
    st_d.spdsel = {pin_lvl.speed_select1, pin_lvl.speed_select0};
    if (st_q.special_function_word_two[`SSF_W2_RAMP_BIT])
    begin
      st_d.acc = accel_time_param;
      st_d.dec = decel_time_param;
      st_d.scv = scurve_time_param;
    end
    else
    begin
      st_d.acc = '0;
      st_d.dec = '0;
      st_d.scv = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q                           <= '0;
      st_q.word_one                  <= `SSF_WORD_ONE_RESET;
      st_q.special_function_word_two <= `SSF_WORD_TWO_RESET;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign param_rdata                = st_q.rdata;
  assign pulse_fwd_out              = st_q.fwd;
  assign pulse_rev_out              = st_q.rev;
  assign phase_loss_alarm           = st_q.phase;
  assign encoder_output_error_alarm = st_q.encout;
  assign undervoltage_fault         = st_q.uv;
  assign motor_overtemp_warning     = st_q.temp;
  assign torque_source_sel          = st_q.tsel;
  assign torque_out                 = st_q.torque;
  assign speed_limit_active         = st_q.spdlim;
  assign speed_limit_sel            = st_q.spdsel;
  assign accel_time                 = st_q.acc;
  assign decel_time                 = st_q.dec;
  assign scurve_time                = st_q.scv;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence inhibit_both_s;
    ce && inhibit && pulse_position_mode
    && pin_lvl.forward_limit_input && pin_lvl.reverse_limit_input;
  endsequence

  sequence uv_hold_s;
    ce && uv_auto == 1'b0 && !detect.undervoltage && !detect.uv_clear;
  endsequence

  free_pass_a: assert property (
    ce && !inhibit |=> pulse_fwd_out == $past(pulse_fwd_in)
    && pulse_rev_out == $past(pulse_rev_in))
    else $error("pulse changed with inhibit clear");
  fwd_block_a: assert property (
    ce && inhibit && pulse_position_mode && pin_lvl.forward_limit_input |=> !pulse_fwd_out)
    else $error("forward pulse passed at forward limit");
  both_block_a: assert property (inhibit_both_s |=> !pulse_fwd_out && !pulse_rev_out)
    else $error("pulse passed with both limits");
  phase_mask_a: assert property (
    ce && st_q.word_one[`SSF_W1_PHASE_BIT] |=> !phase_loss_alarm)
    else $error("phase-loss alarm while suppressed");
  encout_on_a: assert property (
    ce && detect.enc_out_err && !st_q.word_one[`SSF_W1_ENCOUT_BIT]
    |=> encoder_output_error_alarm)
    else $error("encoder-output alarm missed");
  torque_zero_a: assert property (
    ce && pin_lvl.positive_torque_input == pin_lvl.negative_torque_input
    |=> torque_out == '0)
    else $error("torque not zero");
  torque_neg_a: assert property (
    ce && !pin_lvl.positive_torque_input
    && pin_lvl.negative_torque_input && torque_cmd_in != CMD_MIN
    |=> torque_out == -$past(torque_cmd_in))
    else $error("torque not inverted");
  spdlim_always_a: assert property (
    ce && speed_limit_mode_param == `SSF_SPDLIM_ALWAYS |=> speed_limit_active)
    else $error("speed limit off in always mode");
  uv_latch_a: assert property (undervoltage_fault ##0 uv_hold_s |=> undervoltage_fault)
    else $error("undervoltage cleared without request");
  uv_set_a: assert property (ce && detect.undervoltage |=> undervoltage_fault)
    else $error("undervoltage not latched");
  temp_hide_a: assert property (
    ce && st_q.special_function_word_two[`SSF_W2_TEMPHIDE_BIT] |=> !motor_overtemp_warning)
    else $error("temperature warning shown while hidden");
  ramp_sel_a: assert property (
    ce && !st_q.special_function_word_two[`SSF_W2_RAMP_BIT]
    |=> accel_time == '0 && decel_time == '0)
    else $error("ramp times with ramp off");
endmodule

// file: test/ssf_host_model.sv
// host model that writes and reads the special-function words over the parameter port
`timescale 1ns/1ns
`include "ssf_defs.svh"
module ssf_host_model
  import ssf_pkg::*;
(
  // clock
  input  wire logic         clk,
  // parameter port toward the device
  output ssf_param_req_type param_req,
  input  wire logic [15:0]  param_rdata
);
  initial param_req = '0;

  // the host clears bits 14 and 15 of word one and bits 1 and 3 to 6 of word two
  function automatic logic [15:0] clean(input logic [15:0] a, input logic [15:0] d);
    if (a == `SSF_WORD_ONE_ADDR)
      clean = d & 16'h3fff;
    else if (a == `SSF_WORD_TWO_ADDR)
      clean = d & 16'hff85;
    else
      clean = d;
  endfunction

  // one-cycle write strobe, taken at the following edge
  task automatic write_word(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    param_req.addr  <= a;
    param_req.wdata <= clean(a, d);
    param_req.wr_en <= 1'b1;
    @(posedge clk);
    param_req.wr_en <= 1'b0;
  endtask

  // read data lands on the edge that takes the strobe
  task automatic read_word(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    param_req.addr  <= a;
    param_req.rd_en <= 1'b1;
    @(posedge clk);
    param_req.rd_en <= 1'b0;
    #1 d = param_rdata;
  endtask
endmodule

// file: test/servo_special_function_config_bench.sv
// self-checking bench for the special-function configuration block
`timescale 1ns/1ns
`include "ssf_defs.svh"
module servo_special_function_config_bench;
  import ssf_pkg::*;
  logic               clk, rst_b, ce, pos_mode, fwd_in, rev_in, fwd_out, rev_out;
  logic               phase_alm, enc_alm, uv_fault, temp_warn, lim_act;
  logic [1:0]         tq_sel, spd_sel;
  logic [7:0]         lim_mode;
  logic [15:0]        rdata, rd, acc_o, dec_o, sc_o;
  logic signed [15:0] tq_cmd, tq_out;
  ssf_param_req_type  req;
  ssf_pins_type       pins;
  ssf_detect_type     det;
  int                 n_fail, checks_done;

  ssf_core DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .param_req(req), .param_rdata(rdata),
    .pins(pins), .pulse_position_mode(pos_mode), .pulse_fwd_in(fwd_in),
    .pulse_rev_in(rev_in), .pulse_fwd_out(fwd_out), .pulse_rev_out(rev_out),
    .detect(det), .phase_loss_alarm(phase_alm), .encoder_output_error_alarm(enc_alm),
    .undervoltage_fault(uv_fault), .motor_overtemp_warning(temp_warn),
    .torque_cmd_in(tq_cmd), .torque_source_sel(tq_sel), .torque_out(tq_out),
    .speed_limit_mode_param(lim_mode), .accel_time_param(16'h0123),
    .decel_time_param(16'h0456), .scurve_time_param(16'h0789),
    .speed_limit_active(lim_act), .speed_limit_sel(spd_sel), .accel_time(acc_o),
    .decel_time(dec_o), .scurve_time(sc_o));
  ssf_host_model u_host (.clk(clk), .param_req(req), .param_rdata(rdata));

  // free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // pins cross a synchroniser, so settle them well past its latency
  task automatic settle;
    repeat (7) @(posedge clk);
    #1;
  endtask

  // reset values, masking of word one, unmapped place
  task automatic t_regs;
    u_host.read_word(`SSF_WORD_ONE_ADDR, rd);
    chk(rd, `SSF_WORD_ONE_RESET, "word one reset");
    u_host.read_word(`SSF_WORD_TWO_ADDR, rd);
    chk(rd, `SSF_WORD_TWO_RESET, "word two reset");
    u_host.write_word(`SSF_WORD_TWO_ADDR, 16'hffff);
    u_host.write_word(`SSF_WORD_ONE_ADDR, 16'hffff);
    u_host.write_word(16'h0286, 16'h1234);
    u_host.read_word(`SSF_WORD_TWO_ADDR, rd);
    chk(rd, 16'hff85, "word two readback");
    u_host.read_word(`SSF_WORD_ONE_ADDR, rd);
    chk(rd, 16'h3800, "word one readback");
    u_host.read_word(16'h0286, rd);
    chk(rd, 16'h0000, "unmapped read");
  endtask

  // every mix of mode, inhibit bit and the two limits; both pulses offered at once
  task automatic t_pulse;
    logic blk;
    for (int i = 0; i < 16; i++)
    begin
      u_host.write_word(`SSF_WORD_ONE_ADDR, 16'(i[2]) << `SSF_W1_INHIBIT_BIT);
      @(posedge clk);
      pos_mode <= i[3];
      pins.forward_limit_input <= i[1];
      pins.reverse_limit_input <= i[0];
      repeat (6) @(posedge clk);
      fwd_in <= 1'b1;
      rev_in <= 1'b1;
      @(posedge clk);
      fwd_in <= 1'b0;
      rev_in <= 1'b0;
      #1 blk = i[2] & i[3];
      chk(16'(fwd_out), 16'(!(blk & i[1])), "forward pulse");
      chk(16'(rev_out), 16'(!(blk & i[0])), "reverse pulse");
    end
  endtask

  // detectors held on while the suppress bits walk through all values
  task automatic t_alarms;
    @(posedge clk);
    det.phase_loss <= 1'b1;
    det.enc_out_err <= 1'b1;
    det.overtemp <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      u_host.write_word(`SSF_WORD_ONE_ADDR, 16'(i) << `SSF_W1_PHASE_BIT);
      u_host.write_word(`SSF_WORD_TWO_ADDR, 16'(i[0]) << `SSF_W2_TEMPHIDE_BIT);
      repeat (2) @(posedge clk);
      #1;
      chk(16'(phase_alm), 16'(!i[0]), "phase loss alarm");
      chk(16'(enc_alm), 16'(!i[1]), "encoder alarm");
      chk(16'(temp_warn), 16'(!i[0]), "temperature warning");
    end
  endtask

  // latched fault needs the clear pulse; auto mode drops it once the cause is gone
  task automatic t_uv(input logic auto_clr);
    u_host.write_word(`SSF_WORD_TWO_ADDR, 16'(auto_clr) << `SSF_W2_UVAUTO_BIT);
    @(posedge clk);
    det.undervoltage <= 1'b1;
    @(posedge clk);
    det.undervoltage <= 1'b0;
    #1 chk(16'(uv_fault), 16'h0001, "fault set");
    repeat (4) @(posedge clk);
    #1 chk(16'(uv_fault), 16'(!auto_clr), "fault after cause gone");
    @(posedge clk);
    det.uv_clear <= 1'b1;
    @(posedge clk);
    det.uv_clear <= 1'b0;
    #1 chk(16'(uv_fault), 16'h0000, "fault cleared");
  endtask

  // all four torque input codes, with the source selects following along
  task automatic t_torque;
    logic signed [15:0] exp;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      tq_cmd <= 16'sd300;
      pins.positive_torque_input <= i[0];
      pins.negative_torque_input <= i[1];
      pins.torque_source_sel0 <= i[0];
      pins.torque_source_sel1 <= i[1];
      settle();
      exp = (i == 1) ? 16'sd300 : (i == 2) ? -16'sd300 : 16'sd0;
      chk(tq_out, exp, "torque out");
      chk(16'(tq_sel), 16'(i), "torque source");
    end
    @(posedge clk);
    tq_cmd <= 16'sh8000;
    pins.positive_torque_input <= 1'b0;
    settle();
    chk(tq_out, 16'h7fff, "negated minimum");
  endtask

  // permanent speed limit and ramp selection
  task automatic t_speed;
    u_host.write_word(`SSF_WORD_TWO_ADDR, 16'h0001);
    @(posedge clk);
    lim_mode <= `SSF_SPDLIM_ALWAYS;
    pins.speed_select1 <= 1'b1;
    settle();
    chk(16'(lim_act), 16'h0001, "limit always on");
    chk(16'(spd_sel), 16'h0002, "speed select");
    chk(acc_o, 16'h0123, "accel time");
    chk(dec_o, 16'h0456, "decel time");
    chk(sc_o, 16'h0789, "s-curve time");
    @(posedge clk);
    lim_mode <= 8'h00;
    repeat (2) @(posedge clk);
    #1 chk(16'(lim_act), 16'h0000, "limit off");
    @(posedge clk);
    pins.speed_limit_input <= 1'b1;
    settle();
    chk(16'(lim_act), 16'h0001, "limit by input");
    u_host.write_word(`SSF_WORD_TWO_ADDR, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk(acc_o | dec_o | sc_o, 16'h0000, "ramp deselected");
  endtask

  // enable low freezes the latch; set beats clear; a mid-run reset restores word one
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    det.undervoltage <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(16'(uv_fault), 16'h0000, "fault frozen while disabled");
    @(posedge clk);
    ce <= 1'b1;
    det.uv_clear <= 1'b1;
    @(posedge clk);
    det.undervoltage <= 1'b0;
    det.uv_clear <= 1'b0;
    #1 chk(16'(uv_fault), 16'h0001, "set beats clear");
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1 chk(16'({uv_fault, temp_warn}), 16'h0000, "outputs in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    u_host.read_word(`SSF_WORD_ONE_ADDR, rd);
    chk(rd, `SSF_WORD_ONE_RESET, "word one after reset");
    chk(16'(phase_alm), 16'h0001, "phase alarm after reset");
  endtask

  // main sequence
  initial
  begin
    {rst_b, pos_mode, fwd_in, rev_in, lim_mode, tq_cmd} = '0;
    pins = '0;
    det = '0;
    ce = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_pulse();
    t_alarms();
    t_uv(1'b0);
    t_uv(1'b1);
    t_torque();
    t_speed();
    t_freeze();
    summarize();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
